/* design/sliu_pkg.sv */
// Constants for the single-level interrupt unit: widths, latencies, field positions.
// Assumes one instruction clock; every latency below is in instruction cycles.
package sliu_pkg;
    localparam int PC_W = 12;
    localparam int DATA_W = 8;
    localparam int PIN_N = 8;
    localparam int TIMER_N = 2;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] LAT_TICK_CYC = 3'h3;
    localparam logic [CNT_W-1:0] LAT_PIN_CYC = 3'h5;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [PC_W-1:0] PC_VECTOR = 12'h000;
    localparam logic [DATA_W-1:0] TICK_MAX = 8'hFF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [PIN_N-1:0] PINS_ZERO = 8'h00;
    localparam int PAGE_LSB = 5;
    localparam int PAGE_MSB = 7;
    localparam int OVF_FLAG_BIT = 7;
    localparam logic EDGE_RISE = 1'b0;

    typedef enum logic [1:0] {
        SLIU_IDLE = 2'b00,
        SLIU_WAIT = 2'b01,
        SLIU_SERVICE = 2'b10
    } sliu_state_t;
endpackage

/* design/sliu_wake_if.sv */
// Carrier between the interrupt core and the pin wakeup sensing module.
// Assumes both ends run on the same instruction clock.
`timescale 1ns/100ps
interface sliu_wake_if;
    logic [sliu_pkg::PIN_N-1:0] pins;
    logic [sliu_pkg::PIN_N-1:0] enable;
    logic [sliu_pkg::PIN_N-1:0] edge_sel;
    logic xchg;
    logic [sliu_pkg::PIN_N-1:0] wdata;
    logic [sliu_pkg::PIN_N-1:0] flags;
    logic [sliu_pkg::PIN_N-1:0] hit;
    logic [sliu_pkg::PIN_N-1:0] rdata;

    modport core (output pins, output enable, output edge_sel, output xchg, output wdata,
                  input flags, input hit, input rdata);
    modport wake (input pins, input enable, input edge_sel, input xchg, input wdata,
                  output flags, output hit, output rdata);
endinterface

/* design/sliu_wake.sv */
// Pin edge sensing with per-pin enable, edge select and sticky pending flags.
// Assumes pins are already synchronous to clk_in.
`timescale 1ns/100ps
module sliu_wake (
    input wire logic clk_in,
    input wire logic rstn_in,
    sliu_wake_if.wake wk
);
    logic [sliu_pkg::PIN_N-1:0] prev_q;
    logic armed_q;
    logic [sliu_pkg::PIN_N-1:0] flags_q;
    logic [sliu_pkg::PIN_N-1:0] rdata_q;

    // Selected edge per pin
    function automatic logic [sliu_pkg::PIN_N-1:0] sel_edge(
        input logic [sliu_pkg::PIN_N-1:0] now, input logic [sliu_pkg::PIN_N-1:0] old,
        input logic [sliu_pkg::PIN_N-1:0] sel);
        logic [sliu_pkg::PIN_N-1:0] r;
        r = ((now & ~old) & ~sel) | ((~now & old) & sel);
        return r;
    endfunction

    // Not armed on the first cycle, so reset value of prev_q fakes no edge
    assign wk.hit = armed_q ? (sel_edge(wk.pins, prev_q, wk.edge_sel) & wk.enable)
                            : sliu_pkg::PINS_ZERO;
    assign wk.flags = flags_q;
    assign wk.rdata = rdata_q;

    // Previous pin level
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            prev_q <= sliu_pkg::PINS_ZERO;
            armed_q <= 1'b0;
        end else begin
            prev_q <= wk.pins;
            armed_q <= 1'b1;
        end
    end

    // Pending flags; a new edge wins over the swap write
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            flags_q <= sliu_pkg::PINS_ZERO;
        end else if (wk.xchg) begin
            flags_q <= wk.wdata | wk.hit;
        end else begin
            flags_q <= flags_q | wk.hit;
        end
    end

    // Old flag contents returned by the swap
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_q <= sliu_pkg::PINS_ZERO;
        end else if (wk.xchg) begin
            rdata_q <= flags_q;
        end
    end

    a_flag_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (|wk.hit) |=> ((flags_q & $past(wk.hit)) == $past(wk.hit)))
        else $error("pending flag missed a detected edge");

    a_swap_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wk.xchg |=> (rdata_q == $past(flags_q))
                    && ((flags_q & $past(wk.wdata)) == $past(wk.wdata)))
        else $error("swap did not exchange pending flags");
endmodule // sliu_wake

/* design/sliu_top.sv */
// Interrupt unit top: tick counter, source gating, latency, context shadow and return.
// Assumes the core sequencer applies ctx outputs on the load pulses and
// holds pc/acc/status/fsr inputs valid for the current instruction.
`timescale 1ns/100ps
module sliu_top (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic powerdown_in,
    input wire logic tick_inc_in,
    input wire logic tick_load_in,
    input wire logic [sliu_pkg::DATA_W-1:0] tick_wdata_in,
    input wire logic tick_irq_enable_n_in,
    input wire logic tick_ovf_clr_in,
    input wire logic [sliu_pkg::PIN_N-1:0] pins_in,
    input wire logic [sliu_pkg::PIN_N-1:0] wake_enable_in,
    input wire logic [sliu_pkg::PIN_N-1:0] wake_edge_sel_in,
    input wire logic wake_xchg_in,
    input wire logic [sliu_pkg::TIMER_N-1:0] timer_irq_in,
    input wire logic [sliu_pkg::TIMER_N-1:0] timer_irq_en_in,
    input wire logic ret_in,
    input wire logic return_with_tick_adjust_in,
    input wire logic [sliu_pkg::PC_W-1:0] pc_in,
    input wire logic [sliu_pkg::DATA_W-1:0] acc_in,
    input wire logic [sliu_pkg::DATA_W-1:0] status_in,
    input wire logic [sliu_pkg::DATA_W-1:0] file_select_pointer_in,
    output logic [sliu_pkg::DATA_W-1:0] tick_count_out,
    output logic tick_overflow_flag_out,
    output logic [sliu_pkg::PIN_N-1:0] wakeup_pending_flags_out,
    output logic [sliu_pkg::PIN_N-1:0] wake_xchg_data_out,
    output logic vector_load_out,
    output logic return_load_out,
    output logic [sliu_pkg::PC_W-1:0] pc_out,
    output logic [sliu_pkg::DATA_W-1:0] acc_out,
    output logic [sliu_pkg::DATA_W-1:0] status_out,
    output logic [sliu_pkg::DATA_W-1:0] file_select_pointer_out,
    output logic in_service_out,
    output logic wake_reset_out
);
    sliu_wake_if wk ();

    sliu_pkg::sliu_state_t state_q;
    logic [sliu_pkg::CNT_W-1:0] cnt_q;
    logic [sliu_pkg::DATA_W-1:0] tick_q;
    logic tick_req_q;
    logic ovf_flag_q;
    logic [sliu_pkg::PC_W-1:0] sh_pc_q;
    logic [sliu_pkg::DATA_W-1:0] sh_acc_q;
    logic [sliu_pkg::DATA_W-1:0] sh_status_q;
    logic [sliu_pkg::DATA_W-1:0] sh_fsr_q;
    logic vec_q;
    logic ret_q;
    logic [sliu_pkg::PC_W-1:0] pc_q;
    logic [sliu_pkg::DATA_W-1:0] acc_q;
    logic [sliu_pkg::DATA_W-1:0] status_q;
    logic [sliu_pkg::DATA_W-1:0] fsr_q;
    logic wake_reset_q;

    logic tick_roll;
    logic tick_now;
    logic pin_now;
    logic pend_any;
    logic start;
    logic entry;
    logic ret_any;
    logic [sliu_pkg::CNT_W-1:0] lat_sel;

    // Status as seen after entry: page-select bits forced low
    function automatic logic [sliu_pkg::DATA_W-1:0] page_clear(
        input logic [sliu_pkg::DATA_W-1:0] st);
        logic [sliu_pkg::DATA_W-1:0] r;
        r = st;
        r[sliu_pkg::PAGE_MSB:sliu_pkg::PAGE_LSB] = '0;
        return r;
    endfunction

    assign wk.pins = pins_in;
    assign wk.enable = wake_enable_in;
    assign wk.edge_sel = wake_edge_sel_in;
    assign wk.xchg = wake_xchg_in;
    assign wk.wdata = acc_in;

    sliu_wake u_wake (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wk(wk.wake)
    );

    // Source gating; enables decide, not priority
    assign tick_roll = tick_inc_in && !return_with_tick_adjust_in && !tick_load_in
                       && (tick_q == sliu_pkg::TICK_MAX);
    assign tick_now = tick_roll && !tick_irq_enable_n_in;
    assign pin_now = (|wk.hit) && !powerdown_in;
    assign pend_any = tick_req_q || ((|(wk.flags & wake_enable_in)) && !powerdown_in)
                      || (|(timer_irq_in & timer_irq_en_in));
    // Any order: whichever is pending starts the same entry
    assign start = (state_q == sliu_pkg::SLIU_IDLE) && !powerdown_in
                   && (tick_now || pin_now || pend_any);
    // Fresh pin edge without a same-cycle enabled tick rollover uses the long path; older pending levels use the short one
    assign lat_sel = (pin_now && !tick_now) ? sliu_pkg::LAT_PIN_CYC
                                            : sliu_pkg::LAT_TICK_CYC;
    assign entry = (state_q == sliu_pkg::SLIU_WAIT) && (cnt_q == sliu_pkg::CNT_ONE);
    assign ret_any = (state_q == sliu_pkg::SLIU_SERVICE)
                     && (ret_in || return_with_tick_adjust_in);

    // Entry sequencing: idle, latency wait, service
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_q <= sliu_pkg::SLIU_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                sliu_pkg::SLIU_IDLE: begin
                    if (start) begin
                        state_q <= sliu_pkg::SLIU_WAIT;
                        cnt_q <= lat_sel - sliu_pkg::CNT_ONE;
                    end
                end
                sliu_pkg::SLIU_WAIT: begin
                    cnt_q <= cnt_q - sliu_pkg::CNT_ONE;
                    if (entry) begin
                        state_q <= sliu_pkg::SLIU_SERVICE;
                    end
                end
                sliu_pkg::SLIU_SERVICE: begin
                    if (ret_any) begin
                        state_q <= sliu_pkg::SLIU_IDLE;
                    end
                end
                default: begin
                    state_q <= sliu_pkg::SLIU_IDLE;
                end
            endcase
        end
    end

    // Tick counter; adjusting return wraps quietly, load beats increment
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tick_q <= sliu_pkg::DATA_ZERO;
        end else if (ret_any && return_with_tick_adjust_in) begin
            tick_q <= tick_q + acc_in;
        end else if (tick_load_in) begin
            tick_q <= tick_wdata_in;
        end else if (tick_inc_in) begin
            tick_q <= tick_q + 8'h01;
        end
    end

    // Tick request held until entry; a new rollover wins over the clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tick_req_q <= 1'b0;
        end else if (tick_now) begin
            tick_req_q <= 1'b1;
        end else if (entry) begin
            tick_req_q <= 1'b0;
        end
    end

    // Overflow flag for software; set wins over clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ovf_flag_q <= 1'b0;
        end else if (tick_roll) begin
            ovf_flag_q <= 1'b1;
        end else if (tick_ovf_clr_in) begin
            ovf_flag_q <= 1'b0;
        end
    end

    // One-entry shadow, separate from any call stack
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sh_pc_q <= '0;
            sh_acc_q <= sliu_pkg::DATA_ZERO;
            sh_status_q <= sliu_pkg::DATA_ZERO;
            sh_fsr_q <= sliu_pkg::DATA_ZERO;
        end else if (entry) begin
            sh_pc_q <= pc_in;
            sh_acc_q <= acc_in;
            sh_status_q <= status_in;
            sh_fsr_q <= file_select_pointer_in;
        end
    end

    // Context outputs: vector on entry, shadow contents on return
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            vec_q <= 1'b0;
            ret_q <= 1'b0;
            pc_q <= '0;
            acc_q <= sliu_pkg::DATA_ZERO;
            status_q <= sliu_pkg::DATA_ZERO;
            fsr_q <= sliu_pkg::DATA_ZERO;
        end else begin
            vec_q <= entry;
            ret_q <= ret_any;
            if (entry) begin
                pc_q <= sliu_pkg::PC_VECTOR;
                acc_q <= acc_in;
                status_q <= page_clear(status_in);
                fsr_q <= file_select_pointer_in;
            end else if (ret_any) begin
                pc_q <= sh_pc_q;
                acc_q <= sh_acc_q;
                status_q <= sh_status_q;
                fsr_q <= sh_fsr_q;
            end
        end
    end

    // Power-down wake: reset request instead of interrupt
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wake_reset_q <= 1'b0;
        end else begin
            wake_reset_q <= powerdown_in && (|wk.hit);
        end
    end

    assign tick_count_out = tick_q;
    assign tick_overflow_flag_out = ovf_flag_q;
    assign wakeup_pending_flags_out = wk.flags;
    assign wake_xchg_data_out = wk.rdata;
    assign vector_load_out = vec_q;
    assign return_load_out = ret_q;
    assign pc_out = pc_q;
    assign acc_out = acc_q;
    assign status_out = status_q;
    assign file_select_pointer_out = fsr_q;
    assign in_service_out = (state_q == sliu_pkg::SLIU_SERVICE);
    assign wake_reset_out = wake_reset_q;

    sequence s_tick_start;
        start && tick_now;
    endsequence
    sequence s_pin_start;
        start && pin_now && !tick_now;
    endsequence

    a_tick_latency: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_tick_start |-> ##1 !vec_q [*2] ##1 vec_q)
        else $error("tick entry not three cycles after rollover");

    a_pin_latency: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_pin_start |-> ##1 !vec_q [*4] ##1 vec_q)
        else $error("pin entry not five cycles after edge");

    a_vector_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
        vec_q |-> (pc_q == sliu_pkg::PC_VECTOR) && $past(pc_in) == sh_pc_q)
        else $error("entry did not vector to zero with pc saved");

    a_page_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
        vec_q |-> (status_q[sliu_pkg::PAGE_MSB:sliu_pkg::PAGE_LSB] == 3'h0)
                  && (sh_status_q == $past(status_in)))
        else $error("page bits not cleared after status save");

    a_mask_service: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_q == sliu_pkg::SLIU_SERVICE) && !ret_any |=> !vec_q && !start)
        else $error("interrupt accepted during service");

    a_shadow_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_q == sliu_pkg::SLIU_SERVICE) |=> $stable(sh_pc_q) && $stable(sh_status_q))
        else $error("shadow changed during service");

    a_return_restore: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ret_any |=> ret_q && (pc_q == sh_pc_q) && (acc_q == sh_acc_q) && (fsr_q == sh_fsr_q))
        else $error("return did not restore context");

    a_retrigger: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ret_any && tick_req_q && !powerdown_in |=> start)
        else $error("pending tick not retaken after return");

    a_tick_adjust: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ret_any && return_with_tick_adjust_in |=>
            (tick_q == $past(tick_q) + $past(acc_in)) && ($past(tick_req_q) || !tick_req_q))
        else $error("adjusting return sum wrong or raised a request");

    a_disabled_tick: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tick_roll && tick_irq_enable_n_in && !tick_req_q |=> !tick_req_q)
        else $error("disabled rollover raised a request");

    a_pd_wake: assert property (@(posedge clk_in) disable iff (!rstn_in)
        powerdown_in && (|wk.hit) |-> !start ##1 wake_reset_q)
        else $error("power-down edge did not request reset");
endmodule // sliu_top

/* sim/sliu_core_model.sv */
// Behavioural model of the core sequencer that sits beside the interrupt unit.
// Assumes the unit's load pulses are one cycle wide and its context outputs valid with them.
`timescale 1ns/100ps
module sliu_core_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic vector_load_in,
    input wire logic return_load_in,
    input wire logic [11:0] pc_ld_in,
    input wire logic [7:0] acc_ld_in,
    input wire logic [7:0] status_ld_in,
    input wire logic [7:0] fsr_ld_in,
    input wire logic wr_in,
    input wire logic [7:0] acc_wr_in,
    input wire logic [7:0] status_wr_in,
    input wire logic [7:0] fsr_wr_in,
    output logic [11:0] pc_out,
    output logic [7:0] acc_out,
    output logic [7:0] status_out,
    output logic [7:0] fsr_out
);
    // Program counter keeps stepping so each entry saves a different address
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pc_out <= 12'h000;
            acc_out <= 8'h00;
            status_out <= 8'h00;
            fsr_out <= 8'h00;
        end else if (vector_load_in || return_load_in) begin
            pc_out <= pc_ld_in;
            acc_out <= acc_ld_in;
            status_out <= status_ld_in;
            fsr_out <= fsr_ld_in;
        end else begin
            pc_out <= pc_out + 12'h001;
            // Software writes stand in for instructions touching the registers
            if (wr_in) begin
                acc_out <= acc_wr_in;
                status_out <= status_wr_in;
                fsr_out <= fsr_wr_in;
            end
        end
    end
endmodule // sliu_core_model

/* sim/tb.sv */
// Self-checking bench: tick, pin, timer entries, masking, returns, swap, power-down.
// Assumes sliu_top and the core model; stimulus changes on clk_in rising edges.
`timescale 1ns/100ps
module tb;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic pd = 1'b0;
    logic ten_n = 1'b1;
    logic [6:0] cmd = 7'h00;
    logic [23:0] wrv = 24'h000000;
    logic [7:0] pins = 8'h00;
    logic [7:0] wen = 8'h00;
    logic [7:0] wsel = 8'h00;
    logic [1:0] tirq = 2'h0;
    logic [1:0] ten = 2'h0;
    logic [11:0] m_pc, pc_out;
    logic [7:0] m_acc, m_st, m_fsr, acc_out, status_out, fsr_out, tick_q, flags, xdata;
    logic vector_load_out, return_load_out, in_service_out, ovf, wake_reset_out;
    logic [35:0] snap = 36'h0;
    logic [35:0] saved = 36'h0;
    logic [31:0] seed = 32'h000164D6;
    logic [31:0] r;
    logic [7:0] a;
    int num_errors = 0;
    int n_compared = 0;

    sliu_top sliu_top_i (.clk_in(clk_in), .rstn_in(rstn_in), .powerdown_in(pd),
        .tick_inc_in(cmd[0]), .tick_load_in(cmd[4]), .tick_wdata_in(wrv[7:0]),
        .tick_irq_enable_n_in(ten_n), .tick_ovf_clr_in(cmd[5]), .pins_in(pins),
        .wake_enable_in(wen), .wake_edge_sel_in(wsel), .wake_xchg_in(cmd[3]),
        .timer_irq_in(tirq), .timer_irq_en_in(ten), .ret_in(cmd[1]),
        .return_with_tick_adjust_in(cmd[2]), .pc_in(m_pc), .acc_in(m_acc),
        .status_in(m_st), .file_select_pointer_in(m_fsr), .tick_count_out(tick_q),
        .tick_overflow_flag_out(ovf), .wakeup_pending_flags_out(flags),
        .wake_xchg_data_out(xdata), .vector_load_out(vector_load_out),
        .return_load_out(return_load_out), .pc_out(pc_out), .acc_out(acc_out),
        .status_out(status_out), .file_select_pointer_out(fsr_out),
        .in_service_out(in_service_out), .wake_reset_out(wake_reset_out));
    sliu_core_model sliu_core_model_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .vector_load_in(vector_load_out), .return_load_in(return_load_out),
        .pc_ld_in(pc_out), .acc_ld_in(acc_out), .status_ld_in(status_out),
        .fsr_ld_in(fsr_out), .wr_in(cmd[6]), .acc_wr_in(wrv[7:0]),
        .status_wr_in(wrv[15:8]), .fsr_wr_in(wrv[23:16]), .pc_out(m_pc),
        .acc_out(m_acc), .status_out(m_st), .fsr_out(m_fsr));

    // Clock, and a copy of the core context as the unit sampled it
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) snap <= {m_pc, m_acc, m_st, m_fsr};

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Adjusting return sum wraps at eight bits
    function automatic logic [7:0] adj_sum(input logic [7:0] t0, input logic [7:0] w);
        return t0 + w;
    endfunction

    task end_sim;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask

    // One-cycle command pulse; cmd bits: inc, ret, retw, xchg, load, ovf clear, ctx write
    task pulse(input int k, input logic [23:0] v);
        @(posedge clk_in);
        cmd <= 7'h01 << k;
        wrv <= v;
        @(posedge clk_in);
        cmd <= 7'h00;
        #1;
    endtask

    task setpins(input logic [7:0] v);
        @(posedge clk_in);
        pins <= v;
        @(posedge clk_in);
        #1;
    endtask

    task quiet(input int k);
        repeat (k) begin
            @(posedge clk_in);
            #1;
            chk("no entry", 36'(vector_load_out), 36'h0);
        end
    endtask

    // Bounded wait for entry, then checks of the vectored context
    task entry(input int lat);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (vector_load_out !== 1'b1 && n < 12);
        if (vector_load_out !== 1'b1) begin
            num_errors++;
            $display("FAIL vector_load expected 1 seen 0");
            end_sim;
        end
        if (lat < 0)
            chk("retrigger", 36'(n >= 2 && n <= 5), 36'h1);
        else
            chk("latency", 36'(n + 1), 36'(lat));
        chk("pc vector", 36'(pc_out), 36'h0);
        chk("page bits", 36'(status_out), 36'({3'h0, snap[12:8]}));
        chk("acc saved", 36'(acc_out), 36'(snap[23:16]));
        chk("fsr saved", 36'(fsr_out), 36'(snap[7:0]));
        chk("in service", 36'(in_service_out), 36'h1);
        saved = snap;
    endtask

    // Context is scrambled first, so a return must restore the saved copy
    task do_ret(input int k, input logic [7:0] acc);
        logic [31:0] t;
        int i;
        t = rnd();
        pulse(6, {t[15:0], acc});
        pulse(k, 24'h000000);
        i = 0;
        while (return_load_out !== 1'b1 && i < 4) begin
            @(posedge clk_in);
            #1;
            i++;
        end
        if (return_load_out !== 1'b1) begin
            num_errors++;
            $display("FAIL return_load expected 1 seen 0");
            end_sim;
        end
        chk("restore", {pc_out, acc_out, status_out, fsr_out}, saved);
    endtask

    // Service routine swap: old flags out, accumulator value in
    task swp(input logic [7:0] acc, input logic [7:0] old_f, input logic [7:0] new_f);
        pulse(6, {16'h0000, acc});
        pulse(3, 24'h000000);
        chk("swap old", 36'(xdata), 36'(old_f));
        chk("swap new", 36'(flags), 36'(new_f));
    endtask

    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk("reset", 36'({vector_load_out, in_service_out, flags, tick_q, ovf}), 36'h0);
        // Tick rollover entry
        r = rnd();
        pulse(6, r[23:0]);
        @(posedge clk_in);
        ten_n <= 1'b0;
        pulse(4, 24'h0000FF);
        pulse(0, 24'h000000);
        chk("tick wrap", 36'(tick_q), 36'h0);
        chk("ovf flag", 36'(ovf), 36'h1);
        entry(3);
        // Pin edge during service is flagged but held off
        @(posedge clk_in);
        wen <= 8'h08;
        setpins(8'h08);
        chk("flag in service", 36'(flags), 36'h08);
        quiet(8);
        // Rollover in service is held as a request and retaken after return
        pulse(4, 24'h0000FF);
        pulse(0, 24'h000000);
        pulse(5, 24'h000000);
        do_ret(1, 8'h3C);
        entry(-1);
        r = rnd();
        swp(r[7:0], 8'h08, r[7:0]);
        swp(8'h00, r[7:0], 8'h00);
        @(posedge clk_in);
        wen <= 8'h00;
        ten_n <= 1'b1;
        do_ret(1, 8'h5A);
        // Every pin, random edge sense, random return kind
        repeat (2) begin
            for (int i = 0; i < 8; i++) begin
                r = rnd();
                @(posedge clk_in);
                pins <= {7'h00, r[i]} << i;
                @(posedge clk_in);
                wen <= 8'h01 << i;
                wsel <= r[7:0];
                setpins(({7'h00, r[i]} << i) ^ (8'h01 << i));
                entry(5);
                chk("pin flag", 36'(flags), 36'(8'h01 << i));
                swp(8'h00, 8'h01 << i, 8'h00);
                @(posedge clk_in);
                wen <= 8'h00;
                do_ret(r[8] ? 2 : 1, r[23:16]);
            end
        end
        // Disabled pins and disabled tick never vector
        setpins(~pins);
        pulse(4, 24'h0000FF);
        pulse(0, 24'h000000);
        quiet(8);
        chk("no flags", 36'(flags), 36'h0);
        // Power-down: an enabled edge asks for reset, not entry
        @(posedge clk_in);
        pd <= 1'b1;
        wen <= 8'hFF;
        wsel <= 8'h00;
        pins <= 8'h00;
        setpins(8'hFF);
        a = 8'h00;
        repeat (2) begin
            if (wake_reset_out === 1'b1)
                a = 8'h01;
            @(posedge clk_in);
            #1;
        end
        chk("wake reset", 36'(a), 36'h1);
        quiet(6);
        swp(8'h00, 8'hFF, 8'h00);
        @(posedge clk_in);
        pd <= 1'b0;
        wen <= 8'h00;
        // Timer sources gated by their enables, then adjusting return
        @(posedge clk_in);
        ten <= 2'b10;
        tirq <= 2'b01;
        quiet(6);
        @(posedge clk_in);
        tirq <= 2'b10;
        @(posedge clk_in);
        #1;
        entry(3);
        @(posedge clk_in);
        tirq <= 2'b00;
        ten_n <= 1'b0;
        pulse(5, 24'h000000);
        pulse(4, 24'h0000F0);
        r = rnd();
        a = r[7:0] | 8'h80;
        do_ret(2, a);
        chk("adjust sum", 36'(tick_q), 36'(adj_sum(8'hF0, a)));
        chk("adjust flag", 36'(ovf), 36'h0);
        quiet(6);
        end_sim;
    end
endmodule // tb
